// File: exposure_timing_pkg.sv
// exposure and frame timing control: constants, register map, carrier types
// assumes a 50 MHz system clock; all timer settings are in microseconds
package exposure_timing_pkg;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int US_CYC = CLK_MHZ;
    localparam real EXT_TIME_US = 77.7;
    localparam real JIT_FV_HIGH_US = 25.0;
    localparam real JIT_FV_LOW_US = 11.5;
    localparam int EXT_CYC = int'(EXT_TIME_US * real'(CLK_MHZ));
    // both start jitter delays round down
    localparam int JIT_HIGH_CYC = $rtoi(JIT_FV_HIGH_US * real'(CLK_MHZ));
    localparam int JIT_LOW_CYC = $rtoi(JIT_FV_LOW_US * real'(CLK_MHZ));

    // ---------------------------------------------------------------
    // register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TIMER1 = 8'h04;
    localparam logic [7:0] ADDR_TIMER2 = 8'h08;
    localparam logic [7:0] ADDR_GAIN_LEFT = 8'h0c;
    localparam logic [7:0] ADDR_GAIN_RIGHT = 8'h10;
    localparam logic [7:0] ADDR_OFFSET_LEFT = 8'h14;
    localparam logic [7:0] ADDR_OFFSET_RIGHT = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1c;

    localparam int CTRL_FREE_RUN_BIT = 0;
    localparam int CTRL_OUT8_BIT = 1;
    localparam int STAT_EXPOSING_BIT = 0;
    localparam int STAT_FV_BIT = 1;
    localparam int STAT_PENDING_BIT = 2;
    localparam int STAT_FREE_RUN_BIT = 3;

    localparam logic [15:0] TIMER1_RST = 16'h03e8;
    localparam logic [15:0] TIMER2_RST = 16'h4e20;
    localparam logic [9:0] GAIN_RST = 10'h120;
    localparam logic [9:0] GAIN_MAX = 10'h239;
    localparam logic [7:0] OFFSET_RST = 8'h00;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_EXPOSE = 2'b10,
        ST_HIGH = 2'b11
    } exp_state_type;

    typedef struct packed {
        logic free_run;
        logic out8;
        logic [15:0] t1;
        logic [15:0] t2;
    } cfg_type;

    typedef struct packed {
        logic [9:0] left;
        logic [9:0] right;
    } pixel_pair_type;

    typedef struct packed {
        logic [9:0] gain;
        logic [7:0] offset;
    } channel_set_type;

    function automatic logic [23:0] us_to_cyc(input logic [15:0] us);
        return 24'(32'(us) * 32'(US_CYC));
    endfunction : us_to_cyc

endpackage : exposure_timing_pkg

// File: exposure_timing_control.sv
// exposure timing, free-run control, video output mode and channel settings
// assumes an APB master on clk_sys_i; trigger and pixel clock arrive
// asynchronously from the frame grabber side; sensor data is on clk_sys_i
`timescale 1ns/1ns
module exposure_timing_control
    import exposure_timing_pkg::*;
#(
    parameter int FRAME_PAIRS = 504008
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // frame grabber link
    input wire logic trigger_i,
    input wire logic pixel_clk_i,
    output logic frame_valid_o,
    output pixel_pair_type pixel_o,
    output logic pixel_valid_o,
    output logic exposure_active_out_o,
    // sensor data and variable_gain_stage settings
    input wire pixel_pair_type sensor_i,
    output channel_set_type left_set_o,
    output channel_set_type right_set_o
);

    localparam int PAIR_W = $clog2(FRAME_PAIRS + 1);
    localparam logic [PAIR_W-1:0] LAST_PAIR = PAIR_W'(FRAME_PAIRS - 1);
    localparam logic [23:0] EXT_CYC_W = 24'(EXT_CYC);
    localparam logic [23:0] JIT_HIGH_W = 24'(JIT_HIGH_CYC);
    localparam logic [23:0] WAIT_MAX = JIT_HIGH_W - 24'h00_0004;
    localparam int JIT_LOW_BOUND = JIT_LOW_CYC;

    // ---------------------------------------------------------------
    // software registers
    // ---------------------------------------------------------------
    logic free_run_reg;
    logic out8_reg;
    logic [15:0] timer1_reg;
    logic [15:0] timer2_reg;
    channel_set_type left_reg;
    channel_set_type right_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;

    // state
    exp_state_type state_reg;
    cfg_type cfg_act_reg;
    logic [23:0] cnt_reg;
    logic exposing_reg;
    logic rd_start_reg;
    logic fv_reg;
    logic rd_out8_reg;
    logic [PAIR_W-1:0] pair_cnt_reg;
    pixel_pair_type pix_reg;
    logic pix_valid_reg;

    // synchronisers
    logic trig_meta_reg;
    logic trig_sync_reg;
    logic trig_last_reg;
    logic pclk_meta_reg;
    logic pclk_sync_reg;
    logic pclk_last_reg;

    logic setup_phase;
    logic access_done;
    logic trig_rise;
    logic pclk_rise;
    logic [23:0] exp_target;
    logic [23:0] high_target;
    logic [9:0] wr_gain;

    assign setup_phase = psel_i && !penable_i;
    assign access_done = psel_i && penable_i && pready_reg;
    assign trig_rise = trig_sync_reg && !trig_last_reg;
    assign pclk_rise = pclk_sync_reg && !pclk_last_reg;
    assign exp_target = us_to_cyc(cfg_act_reg.t1) + EXT_CYC_W;
    assign high_target = us_to_cyc(cfg_act_reg.t2);
    // values above the top of the gain scale are clamped
    assign wr_gain = (pwdata_i[9:0] > GAIN_MAX) ? GAIN_MAX : pwdata_i[9:0];

    // ---------------------------------------------------------------
    // apb slave: zero wait states, answer prepared in the setup cycle
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else if (setup_phase) begin
            pready_reg <= 1'b1;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            unique case (paddr_i)
                ADDR_CTRL: begin
                    prdata_reg[CTRL_FREE_RUN_BIT] <= free_run_reg;
                    prdata_reg[CTRL_OUT8_BIT] <= out8_reg;
                end
                ADDR_TIMER1: prdata_reg[15:0] <= timer1_reg;
                ADDR_TIMER2: prdata_reg[15:0] <= timer2_reg;
                ADDR_GAIN_LEFT: prdata_reg[9:0] <= left_reg.gain;
                ADDR_GAIN_RIGHT: prdata_reg[9:0] <= right_reg.gain;
                ADDR_OFFSET_LEFT: prdata_reg[7:0] <= left_reg.offset;
                ADDR_OFFSET_RIGHT: prdata_reg[7:0] <= right_reg.offset;
                ADDR_STATUS: begin
                    prdata_reg[STAT_EXPOSING_BIT] <= exposing_reg;
                    prdata_reg[STAT_FV_BIT] <= fv_reg;
                    prdata_reg[STAT_PENDING_BIT] <= (state_reg == ST_WAIT);
                    prdata_reg[STAT_FREE_RUN_BIT] <= cfg_act_reg.free_run;
                end
                default: pslverr_reg <= 1'b1;
            endcase
        end else begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    // register writes take effect at the completing access edge
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            free_run_reg <= 1'b0;
            out8_reg <= 1'b0;
            timer1_reg <= TIMER1_RST;
            timer2_reg <= TIMER2_RST;
            left_reg <= '{gain: GAIN_RST, offset: OFFSET_RST};
            right_reg <= '{gain: GAIN_RST, offset: OFFSET_RST};
        end else if (access_done && pwrite_i) begin
            unique case (paddr_i)
                ADDR_CTRL: begin
                    free_run_reg <= pwdata_i[CTRL_FREE_RUN_BIT];
                    out8_reg <= pwdata_i[CTRL_OUT8_BIT];
                end
                ADDR_TIMER1: timer1_reg <= pwdata_i[15:0];
                ADDR_TIMER2: timer2_reg <= pwdata_i[15:0];
                ADDR_GAIN_LEFT: left_reg.gain <= wr_gain;
                ADDR_GAIN_RIGHT: right_reg.gain <= wr_gain;
                ADDR_OFFSET_LEFT: left_reg.offset <= pwdata_i[7:0];
                ADDR_OFFSET_RIGHT: right_reg.offset <= pwdata_i[7:0];
                default: begin
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // synchronisers for the link inputs
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            trig_meta_reg <= 1'b0;
            trig_sync_reg <= 1'b0;
            trig_last_reg <= 1'b0;
        end else begin
            trig_meta_reg <= trigger_i;
            trig_sync_reg <= trig_meta_reg;
            trig_last_reg <= trig_sync_reg;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pclk_meta_reg <= 1'b0;
            pclk_sync_reg <= 1'b0;
            pclk_last_reg <= 1'b0;
        end else begin
            pclk_meta_reg <= pixel_clk_i;
            pclk_sync_reg <= pclk_meta_reg;
            pclk_last_reg <= pclk_sync_reg;
        end
    end

    // ---------------------------------------------------------------
    // exposure sequencer
    // ---------------------------------------------------------------
    // in triggered mode cnt_reg runs from the trigger edge, so any start
    // delay is taken out of the exposure and the end stays fixed
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 24'h00_0000;
            exposing_reg <= 1'b0;
            rd_start_reg <= 1'b0;
            cfg_act_reg <= '{free_run: 1'b0, out8: 1'b0, t1: TIMER1_RST, t2: TIMER2_RST};
        end else begin
            rd_start_reg <= 1'b0;
            unique case (state_reg)
                ST_IDLE: begin
                    // frame boundary: pick up new settings
                    cfg_act_reg <= '{free_run: free_run_reg, out8: out8_reg,
                                     t1: timer1_reg, t2: timer2_reg};
                    cnt_reg <= 24'h00_0000;
                    if (free_run_reg) begin
                        state_reg <= ST_EXPOSE;
                        exposing_reg <= 1'b1;
                    end else if (trig_rise) begin
                        state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    cnt_reg <= cnt_reg + 24'h00_0001;
                    // hold off while the previous frame leaves; forced start allows for sync delay
                    if (!fv_reg || cnt_reg >= WAIT_MAX) begin
                        state_reg <= ST_EXPOSE;
                        exposing_reg <= 1'b1;
                    end
                end
                ST_EXPOSE: begin
                    cnt_reg <= cnt_reg + 24'h00_0001;
                    if (cnt_reg >= exp_target - 24'h00_0001) begin
                        exposing_reg <= 1'b0;
                        rd_start_reg <= 1'b1;
                        cnt_reg <= 24'h00_0000;
                        state_reg <= cfg_act_reg.free_run ? ST_HIGH : ST_IDLE;
                    end
                end
                ST_HIGH: begin
                    cnt_reg <= cnt_reg + 24'h00_0001;
                    if (cnt_reg >= high_target - 24'h00_0001) begin
                        cnt_reg <= 24'h00_0000;
                        cfg_act_reg <= '{free_run: free_run_reg, out8: out8_reg,
                                         t1: timer1_reg, t2: timer2_reg};
                        if (free_run_reg) begin
                            state_reg <= ST_EXPOSE;
                            exposing_reg <= 1'b1;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // readout: frame valid and two pixels per pixel clock
    // ---------------------------------------------------------------
    // a new readout start restarts the frame; the grabber side keeps
    // transfers from overlapping by its own timing
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            fv_reg <= 1'b0;
            rd_out8_reg <= 1'b0;
            pair_cnt_reg <= '0;
        end else if (rd_start_reg) begin
            fv_reg <= 1'b1;
            rd_out8_reg <= cfg_act_reg.out8;
            pair_cnt_reg <= '0;
        end else if (fv_reg && pclk_rise) begin
            pair_cnt_reg <= pair_cnt_reg + PAIR_W'(1);
            if (pair_cnt_reg == LAST_PAIR) begin
                fv_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pix_reg <= '0;
            pix_valid_reg <= 1'b0;
        end else begin
            pix_valid_reg <= fv_reg && pclk_rise && !rd_start_reg;
            if (fv_reg && pclk_rise && !rd_start_reg) begin
                if (rd_out8_reg) begin
                    pix_reg.left <= {2'b00, sensor_i.left[9:2]};
                    pix_reg.right <= {2'b00, sensor_i.right[9:2]};
                end else begin
                    pix_reg <= sensor_i;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign frame_valid_o = fv_reg;
    assign pixel_o = pix_reg;
    assign pixel_valid_o = pix_valid_reg;
    assign exposure_active_out_o = exposing_reg;
    assign left_set_o = left_reg;
    assign right_set_o = right_reg;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence trig_idle_s;
        trig_rise && state_reg == ST_IDLE && !free_run_reg;
    endsequence

    sequence exposure_on_s;
        exposing_reg && state_reg == ST_EXPOSE;
    endsequence

    trig_start_a: assert property (
        state_reg == ST_WAIT |-> cnt_reg <= WAIT_MAX)
        else $error("exposure did not start within the long start jitter");

    fv_low_start_a: assert property (
        trig_idle_s ##1 !fv_reg |-> ##[1:JIT_LOW_BOUND] exposure_on_s)
        else $error("exposure did not start within the short start jitter");

    readout_follow_a: assert property (
        $fell(exposing_reg) |-> ##1 fv_reg)
        else $error("frame valid did not follow the end of exposure");

    exp_end_a: assert property (
        exposure_on_s and (cnt_reg >= exp_target - 24'h00_0001) |=> !exposing_reg)
        else $error("exposure ran past its programmed length");

    exp_hold_a: assert property (
        exposure_on_s and (cnt_reg < exp_target - 24'h00_0001) |=> exposing_reg)
        else $error("exposure ended early");

    free_nopause_a: assert property (
        state_reg == ST_HIGH && cnt_reg >= high_target - 24'h00_0001 && free_run_reg
        |=> exposure_on_s)
        else $error("free-run paused between frames");

    out8_depth_a: assert property (
        pix_valid_reg && rd_out8_reg |-> pix_reg.left[9:8] == 2'b00
        && pix_reg.right[9:8] == 2'b00)
        else $error("8-bit mode pixel exceeds 8 bits");

    gain_range_a: assert property (
        left_reg.gain <= GAIN_MAX && right_reg.gain <= GAIN_MAX)
        else $error("gain setting above top of scale");

    cfg_stable_a: assert property (
        exposing_reg && $past(exposing_reg) |-> $stable(cfg_act_reg))
        else $error("settings changed during an exposure");

    trig_ignore_a: assert property (
        trig_rise && state_reg == ST_EXPOSE |=> state_reg != ST_WAIT)
        else $error("trigger during exposure was not ignored");

endmodule : exposure_timing_control

// File: frame_grabber_model.sv
// frame grabber stand-in: trigger pulses on request, pixel clock during frames
// assumes fire_i is a one-cycle request on clk_sys_i and the bench obeys trigger spacing
`timescale 1ns/1ns
module frame_grabber_model #(
    parameter int HIGH_CYC = 250
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // bench request and link
    input wire logic fire_i,
    input wire logic frame_valid_i,
    output logic trigger_o,
    output logic pixel_clk_o
);
    int hold;

    // trigger held 5 us, safely above the 4 us minimum high time
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            trigger_o <= 1'b0;
            hold <= 0;
        end else if (fire_i && hold == 0) begin
            trigger_o <= 1'b1;
            hold <= HIGH_CYC;
        end else if (hold > 1) begin
            hold <= hold - 1;
        end else begin
            trigger_o <= 1'b0;
            hold <= 0;
        end
    end

    // pixel clock stands still low outside frames; phase unrelated to clk_sys_i
    initial begin
        pixel_clk_o = 1'b0;
        forever begin
            @(posedge frame_valid_i);
            #37;
            while (frame_valid_i) begin
                pixel_clk_o = 1'b1;
                #80;
                pixel_clk_o = 1'b0;
                #80;
            end
        end
    end
endmodule : frame_grabber_model

// File: tb_top.sv
// self-checking bench for exposure_timing_control with an APB master
// assumes the package and the frame grabber model are compiled first
`timescale 1ns/1ns
module tb_top
    import exposure_timing_pkg::*;
;
    localparam int FP = 8;
    localparam logic [31:0] RST_TAB [8] = '{32'h0, 32'h3e8, 32'h4e20, 32'h120,
        32'h120, 32'h0, 32'h0, 32'h0};
    logic clk_sys_i, rst_n_i, psel, penable, pwrite, pready, pslverr, fire;
    logic trigger, pixel_clk, frame_valid, pixel_valid, exposing, out8_m, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [4:0] cur, ev_prev;
    pixel_pair_type pixel, sens;
    channel_set_type left_set, right_set;
    int miscompares, checks_done, cyc, pix_cnt, r1, f1, n, g, ol, orr;
    int ev_cnt[5];
    int ev_cyc[5];

    exposure_timing_control #(.FRAME_PAIRS(FP)) dut (.clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .trigger_i(trigger), .pixel_clk_i(pixel_clk),
        .frame_valid_o(frame_valid), .pixel_o(pixel), .pixel_valid_o(pixel_valid),
        .exposure_active_out_o(exposing), .sensor_i(sens), .left_set_o(left_set),
        .right_set_o(right_set));
    frame_grabber_model grabber (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .fire_i(fire),
        .frame_valid_i(frame_valid), .trigger_o(trigger), .pixel_clk_o(pixel_clk));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t: value %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    task finish_test();
        if (miscompares == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    // one idle edge after each transfer so psel is never lowered and raised at once
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk_sys_i);
            i++;
        end while (pready !== 1'b1 && i < 50);
        chk({31'h0, pready}, 32'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys_i);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, err);
        chk({31'h0, err}, 32'h0);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, rd, err);
        chk(rd, x);
    endtask : rdc

    task automatic wait_ev(input int idx, input int cnt);
        for (int i = 0; i < 20000 && ev_cnt[idx] < cnt; i++) begin
            @(posedge clk_sys_i);
        end
        chk(32'(ev_cnt[idx] >= cnt), 32'h1);
    endtask : wait_ev

    // one triggered exposure; timer1 is rewritten in mid-exposure
    task automatic trig(input int t1, input int jit, input logic [15:0] new_t1);
        int n0, n1, d;
        n0 = ev_cnt[0] + 1;
        n1 = ev_cnt[1] + 1;
        fire <= 1'b1;
        @(posedge clk_sys_i);
        fire <= 1'b0;
        wait_ev(0, n0);
        chk(32'(ev_cyc[0] - ev_cyc[4] <= jit), 32'h1);
        apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
        chk(32'(rd[STAT_EXPOSING_BIT]), 32'h1);
        wr(ADDR_TIMER1, 32'(new_t1));
        wait_ev(1, n1);
        d = ev_cyc[1] - ev_cyc[4] - (t1 * US_CYC + EXT_CYC);
        chk(32'(d >= 0 && d <= 6), 32'h1);
        repeat (4) @(posedge clk_sys_i);
        chk(32'(ev_cyc[2] >= ev_cyc[1] && ev_cyc[2] <= ev_cyc[1] + 2), 32'h1);
    endtask : trig

    // ---------------------------------------------------------------
    // clock, monitor, stimulus
    // ---------------------------------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    initial begin
        #2_000_000;
        miscompares++;
        finish_test();
    end

    // events: exposure rise/fall, frame valid rise/fall, trigger rise
    always @(posedge clk_sys_i) begin
        cyc++;
        cur = {trigger, ~frame_valid, frame_valid, ~exposing, exposing};
        for (int i = 0; i < 5; i++) begin
            if (cur[i] === 1'b1 && ev_prev[i] === 1'b0) begin
                ev_cnt[i]++;
                ev_cyc[i] = cyc;
                if (i == 2 && ev_cnt[2] > 1) begin
                    chk(32'(pix_cnt), 32'(FP));
                    pix_cnt = 0;
                end
            end
        end
        ev_prev = cur;
        if (pixel_valid === 1'b1) begin
            chk(32'(pixel), out8_m ? 32'({2'b00, sens.left[9:2], 2'b00, sens.right[9:2]})
                : 32'(sens));
            pix_cnt++;
            sens <= pixel_pair_type'(20'(xs()));
        end
    end

    initial begin
        {rst_n_i, psel, penable, pwrite, fire, out8_m} = 6'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        sens = '0;
        seed = 32'h0000000b;
        ev_prev = 5'b01010;
        repeat (4) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        chk(32'(left_set), 32'({GAIN_RST, OFFSET_RST}));
        chk(32'(right_set), 32'({GAIN_RST, OFFSET_RST}));
        for (int i = 0; i < 8; i++) begin
            rdc(8'(i * 4), RST_TAB[i]);
        end
        apb(1'b0, 8'h20, 32'h0, rd, err);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, 8'h24, 32'hffffffff, rd, err);
        chk({31'h0, err}, 32'h1);
        g = 288 + int'(xs() % 282);
        ol = int'(xs() % 256);
        orr = int'(xs() % 256);
        wr(ADDR_GAIN_LEFT, 32'h3ff);
        wr(ADDR_GAIN_RIGHT, 32'(g));
        wr(ADDR_OFFSET_LEFT, 32'(ol));
        wr(ADDR_OFFSET_RIGHT, 32'(orr));
        chk(32'(left_set), 32'({GAIN_MAX, 8'(ol)}));
        chk(32'(right_set), 32'({10'(g), 8'(orr)}));
        rdc(ADDR_GAIN_LEFT, 32'h239);
        wr(ADDR_TIMER1, 32'd13);
        trig(13, JIT_LOW_CYC, 16'h0014);
        trig(20, JIT_HIGH_CYC, 16'h0014);
        wait_ev(3, ev_cnt[3] + 1);
        repeat (60) @(posedge clk_sys_i);
        wr(ADDR_CTRL, 32'h2);
        out8_m = 1'b1;
        trig(20, JIT_LOW_CYC, 16'h000d);
        wait_ev(3, ev_cnt[3] + 1);
        repeat (60) @(posedge clk_sys_i);
        wr(ADDR_TIMER2, 32'd35);
        wr(ADDR_CTRL, 32'h1);
        out8_m = 1'b0;
        wait_ev(0, ev_cnt[0] + 1);
        r1 = ev_cyc[0];
        apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
        chk(32'(rd[STAT_FREE_RUN_BIT]), 32'h1);
        wait_ev(1, ev_cnt[1] + 1);
        f1 = ev_cyc[1];
        chk(32'(f1 - r1 - (13 * US_CYC + EXT_CYC) <= 2), 32'h1);
        chk(32'(f1 - r1 >= 13 * US_CYC + EXT_CYC), 32'h1);
        wait_ev(0, ev_cnt[0] + 1);
        chk(32'(ev_cyc[2] >= f1 && ev_cyc[2] <= f1 + 2), 32'h1);
        n = ev_cyc[0] - r1 - (13 * US_CYC + EXT_CYC + 35 * US_CYC);
        chk(32'(n >= -2 && n <= 2), 32'h1);
        wr(ADDR_CTRL, 32'h0);
        n = ev_cnt[0];
        repeat (7000) @(posedge clk_sys_i);
        chk(32'(ev_cnt[0]), 32'(n));
        rdc(ADDR_STATUS, 32'h0);
        chk(32'(pix_cnt), 32'(FP));
        finish_test();
    end
endmodule : tb_top
